// ==== core/dwb_pkg.sv ====
package dwb_pkg;
  localparam int DWB_WORD_W   = 16;
  localparam int DWB_BYTE_W   = 8;
  localparam int DWB_UPPER_HI = 15;
  localparam int DWB_UPPER_LO = 8;
  localparam int DWB_LOWER_HI = 7;
  localparam int DWB_LOWER_LO = 0;
  localparam logic [1:0] DWB_MASK_NONE = 2'h0;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  mask_n;
  } dwb_wr_word_t;

  typedef enum logic [1:0] {
    DWB_IDLE  = 2'h0,
    DWB_READ  = 2'h1,
    DWB_WRITE = 2'h2
  } dwb_state_t;
endpackage

// ==== core/dwb_ddr_word_byte_placement.sv ====
`timescale 1ns/1ps
// How it works
// (R01) read: two bytes per bus clock
// (R02) register read: upper byte after strobe rise
// (R03) register read: lower byte after strobe fall
// (R04) write: upper on clock rise, lower on fall
// (R05) register space always big-endian
// (R06) host centres write data on edges
// (R07) latency writes: strobe masks each byte
// (R08) host leaves strobe undriven, zero latency
// (R09) zero latency writes store whole words
// (R10) device drives strobe low, zero latency
// (R11) strobe high keeps byte, low stores
// (R12) memory space keeps written byte order
module dwb_ddr_word_byte_placement (
  // system
  input  wire logic                 clock,
  input  wire logic                 rst,
  // bus pins
  input  wire logic                 bus_clock_in,
  input  wire logic                 sel_n_in,
  input  wire logic [7:0]           dq_in,
  output logic      [7:0]           dq_out,
  output logic                      dq_oe,
  input  wire logic                 strobe_mask_line_in,
  output logic                      strobe_mask_line_out,
  output logic                      strobe_mask_line_oe,
  // transaction control
  input  wire logic                 rd_start,
  input  wire logic                 wr_start,
  input  wire logic                 zero_latency,
  // read word source
  input  wire logic [15:0]          rd_word,
  output logic                      rd_word_take,
  // write word sink
  output dwb_pkg::dwb_wr_word_t     wr_word,
  output logic                      wr_word_valid
);
  import dwb_pkg::*;

  logic [2:0] ck_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [7:0] dq_s1_reg;
  logic [7:0] dq_s2_reg;
  logic [1:0] st_sync_reg;
  dwb_state_t state_reg;
  dwb_state_t state_next;
  logic       zl_reg;
  logic [7:0] upper_reg;
  logic       upper_mask_reg;
  logic [7:0] lower_hold_reg;

  // first stages feed only second stages
  // no reset here: four reset cycles flush them
  always_ff @(posedge clock)
  begin
    ck_sync_reg <= {ck_sync_reg[1:0], bus_clock_in};
    cs_sync_reg <= {cs_sync_reg[0], sel_n_in};
    dq_s1_reg   <= dq_in;
    dq_s2_reg   <= dq_s1_reg;
    st_sync_reg <= {st_sync_reg[0], strobe_mask_line_in};
  end

  wire ck_rise  = ck_sync_reg[1] & ~ck_sync_reg[2];
  wire ck_fall  = ~ck_sync_reg[1] & ck_sync_reg[2];
  wire sel_act  = ~cs_sync_reg[1];
  wire in_read  = (state_reg == DWB_READ);
  wire in_write = (state_reg == DWB_WRITE);
  // zero latency: strobe is not driven by host, ignore it
  wire st_mask  = zl_reg ? 1'h0 : st_sync_reg[1]; // (R07) (R09)
  // bus edges that belong to a live write frame
  wire wr_rise  = in_write & sel_act & ck_rise;
  wire wr_fall  = in_write & sel_act & ck_fall;

  // idle is one bit away from read and from write
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      DWB_IDLE:
        if (rd_start)
          state_next = DWB_READ;
        else if (wr_start)
          state_next = DWB_WRITE;
      DWB_READ, DWB_WRITE:
        if (!sel_act)
          state_next = DWB_IDLE;
      default:
        state_next = DWB_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= DWB_IDLE;
      zl_reg    <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == DWB_IDLE && wr_start)
        zl_reg <= zero_latency;
    end
  end

  // read: upper byte with strobe high, lower byte with strobe low;
  // strobe follows the sampled clock, so skew is a few system cycles
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dq_out               <= 8'h00;
      dq_oe                <= 1'h0;
      strobe_mask_line_out <= 1'h0;
      strobe_mask_line_oe  <= 1'h0;
      rd_word_take         <= 1'h0;
      lower_hold_reg       <= 8'h00;
    end
    else
    begin
      rd_word_take <= 1'h0;
      dq_oe        <= in_read;
      // zero latency write: strobe driven low by device (R10)
      strobe_mask_line_oe <= in_read | (in_write & zl_reg);
      if (!in_read)
        strobe_mask_line_out <= 1'h0;
      else if (ck_rise)
      begin
        dq_out               <= rd_word[DWB_UPPER_HI:DWB_UPPER_LO]; // (R01) (R02) (R05) (R12)
        lower_hold_reg       <= rd_word[DWB_LOWER_HI:DWB_LOWER_LO];
        strobe_mask_line_out <= 1'h1;
        rd_word_take         <= 1'h1;
      end
      else if (ck_fall)
      begin
        dq_out               <= lower_hold_reg; // (R01) (R03) (R05) (R12)
        strobe_mask_line_out <= 1'h0;
      end
    end
  end

  // write: first byte on rise is upper, second on fall is lower
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      upper_reg      <= 8'h00;
      upper_mask_reg <= 1'h0;
      wr_word        <= '0;
      wr_word_valid  <= 1'h0;
    end
    else
    begin
      wr_word_valid <= 1'h0;
      if (wr_rise)
      begin
        upper_reg      <= dq_s2_reg; // (R04) (R06)
        upper_mask_reg <= st_mask;
      end
      else if (wr_fall)
      begin
        wr_word.data   <= {upper_reg, dq_s2_reg}; // (R04) (R05) (R12)
        // mask_n bit high means byte is stored
        wr_word.mask_n <= ~{upper_mask_reg, st_mask}; // (R07) (R11)
        wr_word_valid  <= 1'h1;
      end
    end
  end

  a_read_upper: assert property (@(posedge clock) disable iff (rst)
    in_read && ck_rise |=> dq_out == $past(rd_word[15:8]) && strobe_mask_line_out) // (R02)
    else $error("upper byte not placed on strobe rise");
  a_read_lower: assert property (@(posedge clock) disable iff (rst)
    in_read && ck_fall |=> dq_out == lower_hold_reg && !strobe_mask_line_out) // (R03)
    else $error("lower byte not placed on strobe fall");
  a_read_take: assert property (@(posedge clock) disable iff (rst)
    rd_word_take |-> $past(in_read && ck_rise)) // (R01)
    else $error("read word taken without clock rise");
  a_write_pair: assert property (@(posedge clock) disable iff (rst)
    wr_word_valid |-> wr_word.data[7:0] == $past(dq_s2_reg)) // (R04)
    else $error("lower write byte not from falling edge");
  a_write_upper: assert property (@(posedge clock) disable iff (rst)
    wr_word_valid |-> wr_word.data[15:8] == $past(upper_reg)) // (R12)
    else $error("upper write byte misplaced");
  a_zl_full: assert property (@(posedge clock) disable iff (rst)
    wr_word_valid && zl_reg |-> wr_word.mask_n == 2'h3) // (R09)
    else $error("zero latency write masked");
  a_mask_low: assert property (@(posedge clock) disable iff (rst)
    in_write && !zl_reg && ck_fall && sel_act && st_sync_reg[1] |=> !wr_word.mask_n[0]) // (R11)
    else $error("high strobe did not mask byte");
  a_zl_strobe: assert property (@(posedge clock) disable iff (rst)
    in_write && zl_reg |=> strobe_mask_line_oe && !strobe_mask_line_out) // (R10)
    else $error("strobe not low in zero latency write");
  a_write_quiet: assert property (@(posedge clock) disable iff (rst)
    in_write |=> !dq_oe) // (R07)
    else $error("data driven during write");

  a_read_drive: assert property (@(posedge clock) disable iff (rst)
    in_read |=> dq_oe && strobe_mask_line_oe) // (R01)
    else $error("read frame without data or strobe drive");
  a_take_single: assert property (@(posedge clock) disable iff (rst)
    rd_word_take |=> !rd_word_take) // (R01)
    else $error("read word taken twice in a row");
  a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
    state_reg == DWB_IDLE |=> !dq_oe && !wr_word_valid) // (R01)
    else $error("bus activity while idle");
  a_latency_float: assert property (@(posedge clock) disable iff (rst)
    in_write && !zl_reg |=> !strobe_mask_line_oe) // (R07)
    else $error("strobe driven while host masks");
  a_mask_upper: assert property (@(posedge clock) disable iff (rst)
    wr_rise && !zl_reg && st_sync_reg[1] |=> upper_mask_reg) // (R11)
    else $error("high strobe on rise not kept as mask");
  a_upper_store: assert property (@(posedge clock) disable iff (rst)
    wr_word_valid |-> wr_word.mask_n[1] == !$past(upper_mask_reg)) // (R07)
    else $error("upper byte mask not applied");

  c_read: cover property (@(posedge clock) disable iff (rst) in_read && ck_fall);
  c_write: cover property (@(posedge clock) disable iff (rst) wr_word_valid && !zl_reg);
  c_masked: cover property (@(posedge clock) disable iff (rst) wr_word_valid && wr_word.mask_n != 2'h3);
  c_zl: cover property (@(posedge clock) disable iff (rst) wr_word_valid && zl_reg);
  c_upper_kept: cover property (@(posedge clock) disable iff (rst) wr_word_valid && !wr_word.mask_n[1]);
endmodule

// ==== verif/dwb_host_model.sv ====
`timescale 1ns/1ps
module dwb_host_model (
  // host side of the bus
  output logic       bus_clock_in,
  output logic       sel_n_in,
  output logic [7:0] dq_in,
  output logic       host_s
);
  // clock stands low outside frames
  initial
  begin
    bus_clock_in = 1'b0;
    sel_n_in = 1'b1;
    dq_in = 8'hA5;
    host_s = 1'b0;
  end
  task automatic cyc(input logic [15:0] w, input logic [1:0] m, input logic drv);
  begin
    dq_in = w[15:8];
    host_s = drv ? m[1] : ~host_s;
    #31.25 bus_clock_in = 1'b1;
    #31.25 dq_in = w[7:0];
    host_s = drv ? m[0] : ~host_s;
    #31.25 bus_clock_in = 1'b0;
    #31.25;
  end
  endtask
  task automatic sel(input logic v);
  begin
    sel_n_in = v;
    // a released bus must not look like it kept its value
    dq_in = ~dq_in;
    #100;
  end
  endtask
endmodule

// ==== verif/dwb_ddr_word_byte_placement_tb_top.sv ====
`timescale 1ns/1ps
module dwb_ddr_word_byte_placement_tb_top;
  import dwb_pkg::*;
  logic         clock, rst, bclk, sel_n, host_s, s_in, s_out, s_oe, dq_oe, prev_s;
  logic         rd_start, wr_start, zero_latency, wr_valid, take;
  logic [7:0]   dq_in, dq_out;
  logic [15:0]  rd_word;
  logic [31:0]  seed;
  dwb_wr_word_t wr_word;
  logic [7:0]   eb_q[$];
  dwb_wr_word_t ew_q[$];
  int           n_mismatch, n_tests, n_take;
  assign s_in = s_oe ? s_out : host_s;
  dwb_host_model host (.bus_clock_in(bclk), .sel_n_in(sel_n), .dq_in(dq_in), .host_s(host_s));
  dwb_ddr_word_byte_placement DUT (.clock(clock), .rst(rst), .bus_clock_in(bclk), .sel_n_in(sel_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .strobe_mask_line_in(s_in),
    .strobe_mask_line_out(s_out), .strobe_mask_line_oe(s_oe), .rd_start(rd_start),
    .wr_start(wr_start), .zero_latency(zero_latency), .rd_word(rd_word), .rd_word_take(take),
    .wr_word(wr_word), .wr_word_valid(wr_valid));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // an unknown output never passes, not even against an unknown sentinel
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e || $isunknown(g))
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [17:0] g, input logic [17:0] e);
    n_tests++;
    if (g !== e || $isunknown(g))
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // an empty queue yields the inverse, so stray outputs count
  // outputs are looked at on the falling edge, where they are settled
  always @(negedge clock)
  begin
    if (dq_oe === 1'b1 && s_out !== prev_s)
      chk_byte(dq_out, eb_q.size() ? eb_q.pop_front() : ~dq_out);
    if (wr_valid === 1'b1)
      chk_word(wr_word, ew_q.size() ? ew_q.pop_front() : ~wr_word);
    if (take === 1'h1)
      n_take++;
    prev_s <= s_out;
  end
  initial
  begin
    seed = 73;
    rst = 1'h1;
    {rd_start, wr_start, zero_latency} = 3'h0;
    rd_word = 16'h0000;
    n_mismatch = 0;
    n_tests = 0;
    n_take = 0;
    repeat (4) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      host.sel(1'b0);
      @(negedge clock) {zero_latency, rd_start, wr_start} = {k[1], k[0], ~k[0]};
      @(negedge clock) {rd_start, wr_start} = 2'h0;
      for (int i = 0; i < 3; i++)
      begin
        seed = xs(seed);
        if (k[0])
        begin
          @(negedge clock) rd_word = seed[15:0];
          eb_q.push_back(seed[15:8]);
          eb_q.push_back(seed[7:0]);
          host.cyc(~{dq_in, dq_in}, 2'h0, 1'b0);
        end
        else
        begin
          ew_q.push_back({seed[31:16], k[1] ? 2'h3 : ~seed[1:0]});
          host.cyc(seed[31:16], seed[1:0], ~k[1]);
        end
      end
      host.sel(1'b1);
    end
    repeat (20) @(posedge clock);
    if (eb_q.size() + ew_q.size() != 0) n_mismatch++;
    // three read frames of three words each
    chk_byte(n_take[7:0], 8'h09);
    stop_test();
  end
endmodule
